// ===== hw/monitor_defines.svh
/*
 Register offsets, reset values, range codes, full-scale figures and timing
 counts of the current monitor. Assumes nothing beyond a SystemVerilog reader.
*/
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

// Register map
`define OFS_SAMPLE_MSB 8'h00
`define OFS_SAMPLE_LSB 8'h01
`define OFS_WARN_MSB 8'h22
`define OFS_WARN_LSB 8'h23
`define OFS_FAST_TRIP 8'h2e
`define OFS_TRIP_RATIO 8'h30
`define OFS_SENSE_RANGE 8'h33

// Reset values
`define RST_FAST_TRIP 8'hbf
`define RST_TRIP_RATIO 4'hf
`define RST_WARN_WORD 10'h3ff
`define RST_SAMPLE_WORD 10'h000

// Range codes taken from the three-state pin
`define RANGE_CODE_LOW 2'b10
`define RANGE_CODE_HIGH 2'b01
`define RANGE_CODE_OPEN 2'b00

// Full scale per range, in microvolts
`define FS_LOW_UV 17'd25000
`define FS_HIGH_UV 17'd50000
`define FS_OPEN_UV 17'd100000

// Fast-trip span and fast-to-slow ratios, in percent
`define TRIP_MIN_PCT 40
`define TRIP_SPAN_PCT 60
`define DAC_FULL 255
`define RATIO_PCT_0 125
`define RATIO_PCT_1 150
`define RATIO_PCT_2 175
`define RATIO_PCT_3 200

// Converter pacing
`define CLK_PERIOD_NS 10
`define SAMPLE_RATE_SPS 10000
`define SAMPLE_PERIOD_NS (1000000000 / `SAMPLE_RATE_SPS)
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

// Serial target address, a plain default
`define TARGET_ADDR 7'h3a

`endif

// ===== hw/monitor_pkg.sv
/*
 Types shared by the current monitor files.
 Assumes the defines header is compiled alongside.
*/
package monitor_pkg;
	typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WDATA, I2C_RDATA, I2C_RACK} i2cState_type;
	typedef logic [1:0] rangeCode_type;
	typedef logic [9:0] splitWord_type;
endpackage : monitor_pkg

// ===== hw/split_word_if.sv
/*
 Byte access to one 10-bit value kept as an upper byte and a two-bit lower byte.
 Assumes the owner drives one-cycle strobes on clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface split_word_if;
	logic wrMsb;
	logic wrLsb;
	logic rdMsb;
	logic [7:0] wrData;
	logic [7:0] msbByte;
	logic [7:0] lsbByte;
	monitor_pkg::splitWord_type word;

	modport owner (output wrMsb, output wrLsb, output rdMsb, output wrData,
		input msbByte, input lsbByte, input word);
	modport store (input wrMsb, input wrLsb, input rdMsb, input wrData,
		output msbByte, output lsbByte, output word);
endinterface : split_word_if

`default_nettype wire

// ===== hw/split_word_reg.sv
/*
 One 10-bit value in split byte layout, loadable by hardware, optionally
 writable by the host, with a lower-byte snapshot taken on upper-byte reads.
 Assumes synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module split_word_reg #(
	parameter bit WRITABLE = 1'b1,
	parameter monitor_pkg::splitWord_type RESET_WORD = 10'h000
) (
	input wire logic clk,
	input wire logic sys_rst,
	split_word_if.store bus,
	input wire logic load,
	input wire monitor_pkg::splitWord_type loadWord
);
	import monitor_pkg::*;

	splitWord_type word_ff;
	splitWord_type nxt_word;
	logic [1:0] shadow_ff;
	logic [1:0] nxt_shadow;

	always_comb
	begin
		nxt_word = word_ff;
		nxt_shadow = shadow_ff;
		if (load)
			nxt_word = loadWord;
		if (WRITABLE && bus.wrMsb)
			nxt_word[9:2] = bus.wrData;
		if (WRITABLE && bus.wrLsb)
			nxt_word[1:0] = bus.wrData[1:0];
		if (bus.rdMsb)
			nxt_shadow = word_ff[1:0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			word_ff <= RESET_WORD;
			shadow_ff <= RESET_WORD[1:0];
		end
		else
		begin
			word_ff <= nxt_word;
			shadow_ff <= nxt_shadow;
		end
	end

	assign bus.msbByte = word_ff[9:2];
	assign bus.lsbByte = {6'h00, (WRITABLE ? word_ff[1:0] : shadow_ff)};
	assign bus.word = word_ff;
endmodule : split_word_reg

`default_nettype wire

// ===== hw/current_range_and_warning_monitor.sv
/*
 Current-sense monitor: serial register target, range capture, fast-trip and
 ratio settings, converter pacing, sample storage and the warning comparator.
 Assumes serial pins and converter signals already synchronous to clk.
*/
//
// Contract
// - The range-select pin state is caught into bits 1:0 of the range register.
// - Pin low gives 10 (25 mV), high gives 01 (50 mV), open gives 00 (100 mV).
// - Current is converted at 10 ksps to 10 bits and the latest result is readable.
// - A result keeps its upper 8 bits in one byte and its lower 2 in the next.
// - Results and the warning threshold use that split byte layout; the fast-trip setting is one byte.
// - The warning comparison runs on each new sample only while power-good is on.
// - A sample above the warning threshold raises the alert output.
// - The protection-mode pin has no effect on the warning comparison.
// - The ratio setting gives 125, 150, 175 or 200 percent, 200 after reset.
// - The host may overwrite the range code at any time and it takes effect.
// - The 8-bit fast-trip setting spans 40 to 100 percent of full scale.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defines.svh"

module current_range_and_warning_monitor #(
	parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
	parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic rangeSelPinLevel,
	input wire logic rangeSelPinOpen,
	input wire logic powerGoodOut,
	input wire logic protectionModePin,
	output logic adcStart,
	input wire logic adcDone,
	input wire monitor_pkg::splitWord_type adcData,
	output monitor_pkg::rangeCode_type rangeCode,
	output logic [7:0] fastTripLevel,
	output logic [1:0] tripRatioSetting,
	output logic [16:0] fastTripUv,
	output logic [16:0] slowTripUv,
	output logic alertOut
);
	import monitor_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Serial target
	i2cState_type state_ff, nxt_state;
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] ptr_ff, nxt_ptr;
	logic sdaOe_ff, nxt_sdaOe;
	logic first_ff, nxt_first;
	logic isRead_ff, nxt_isRead;
	logic sclPrev_ff, sdaPrev_ff;
	logic sclRise, sclFall, startCond, stopCond;
	logic regWr, regRd;
	logic [7:0] rdByte;

	assign sclRise = scl && !sclPrev_ff;
	assign sclFall = !scl && sclPrev_ff;
	assign startCond = scl && sclPrev_ff && sdaPrev_ff && !sdaIn;
	assign stopCond = scl && sclPrev_ff && !sdaPrev_ff && sdaIn;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_sdaOe = sdaOe_ff;
		nxt_first = first_ff;
		nxt_isRead = isRead_ff;
		regWr = 1'b0;
		regRd = 1'b0;
		if (startCond)
		begin
			nxt_state = I2C_ADDR;
			nxt_bitCnt = 4'h0;
			nxt_sdaOe = 1'b0;
		end
		else if (stopCond)
		begin
			nxt_state = I2C_IDLE;
			nxt_sdaOe = 1'b0;
		end
		else if (sclRise)
		begin
			case (state_ff)
				I2C_ADDR, I2C_WDATA:
				begin
					nxt_shift = {shift_ff[6:0], sdaIn};
					nxt_bitCnt = bitCnt_ff + 4'h1;
				end
				// Not-acknowledge ends the read; wait for stop
				I2C_RACK:
					if (sdaIn)
						nxt_state = I2C_IDLE;
				default: ;
			endcase
		end
		else if (sclFall)
		begin
			case (state_ff)
				I2C_ADDR:
					if (bitCnt_ff == 4'h8)
					begin
						if (shift_ff[7:1] == TARGET_ADDR)
						begin
							nxt_state = I2C_ACK;
							nxt_sdaOe = 1'b1;
							nxt_isRead = shift_ff[0];
							nxt_first = 1'b1;
						end
						else
							nxt_state = I2C_IDLE;
					end
				I2C_ACK, I2C_RACK:
					if (isRead_ff)
					begin
						nxt_state = I2C_RDATA;
						nxt_shift = rdByte;
						nxt_bitCnt = 4'h0;
						nxt_sdaOe = !rdByte[7];
						nxt_ptr = ptr_ff + 8'h01;
						regRd = 1'b1;
					end
					else
					begin
						nxt_state = I2C_WDATA;
						nxt_bitCnt = 4'h0;
						nxt_sdaOe = 1'b0;
					end
				I2C_WDATA:
					if (bitCnt_ff == 4'h8)
					begin
						nxt_state = I2C_ACK;
						nxt_sdaOe = 1'b1;
						nxt_first = 1'b0;
						// First byte after the address is the pointer
						if (first_ff)
							nxt_ptr = shift_ff;
						else
						begin
							regWr = 1'b1;
							nxt_ptr = ptr_ff + 8'h01;
						end
					end
				I2C_RDATA:
					if (bitCnt_ff == 4'h7)
					begin
						nxt_state = I2C_RACK;
						nxt_sdaOe = 1'b0;
					end
					else
					begin
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_bitCnt = bitCnt_ff + 4'h1;
						nxt_sdaOe = !shift_ff[6];
					end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff <= I2C_IDLE;
			bitCnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ptr_ff <= 8'h00;
			sdaOe_ff <= 1'b0;
			first_ff <= 1'b0;
			isRead_ff <= 1'b0;
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			sdaOe_ff <= nxt_sdaOe;
			first_ff <= nxt_first;
			isRead_ff <= nxt_isRead;
			sclPrev_ff <= scl;
			sdaPrev_ff <= sdaIn;
		end
	end

	// Open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe = sdaOe_ff;

	////////////////////////////////////////////////////////////////////////////
	// Settings registers
	split_word_if sampleBus ();
	split_word_if warnBus ();
	logic [7:0] fast_ff, nxt_fast;
	logic [3:0] ratio_ff, nxt_ratio;
	logic [3:0] range_ff, nxt_range;
	logic captured_ff;

	assign sampleBus.wrMsb = 1'b0;
	assign sampleBus.wrLsb = 1'b0;
	assign sampleBus.wrData = shift_ff;
	assign sampleBus.rdMsb = regRd && (ptr_ff == `OFS_SAMPLE_MSB);
	assign warnBus.wrMsb = regWr && (ptr_ff == `OFS_WARN_MSB);
	assign warnBus.wrLsb = regWr && (ptr_ff == `OFS_WARN_LSB);
	assign warnBus.wrData = shift_ff;
	assign warnBus.rdMsb = 1'b0;

	always_comb
	begin
		case (ptr_ff)
			`OFS_SAMPLE_MSB: rdByte = sampleBus.msbByte;
			`OFS_SAMPLE_LSB: rdByte = sampleBus.lsbByte;
			`OFS_WARN_MSB: rdByte = warnBus.msbByte;
			`OFS_WARN_LSB: rdByte = warnBus.lsbByte;
			`OFS_FAST_TRIP: rdByte = fast_ff;
			`OFS_TRIP_RATIO: rdByte = {4'h0, ratio_ff};
			`OFS_SENSE_RANGE: rdByte = {4'h0, range_ff};
			default: rdByte = 8'h00;
		endcase
	end

	always_comb
	begin
		nxt_fast = fast_ff;
		nxt_ratio = ratio_ff;
		nxt_range = range_ff;
		if (!captured_ff)
		begin
			if (rangeSelPinOpen)
				nxt_range[1:0] = `RANGE_CODE_OPEN;
			else if (rangeSelPinLevel)
				nxt_range[1:0] = `RANGE_CODE_HIGH;
			else
				nxt_range[1:0] = `RANGE_CODE_LOW;
		end
		if (regWr && (ptr_ff == `OFS_FAST_TRIP))
			nxt_fast = shift_ff;
		if (regWr && (ptr_ff == `OFS_TRIP_RATIO))
			nxt_ratio = shift_ff[3:0];
		if (regWr && (ptr_ff == `OFS_SENSE_RANGE))
			nxt_range = shift_ff[3:0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fast_ff <= `RST_FAST_TRIP;
			ratio_ff <= `RST_TRIP_RATIO;
			range_ff <= 4'h0;
			captured_ff <= 1'b0;
		end
		else
		begin
			fast_ff <= nxt_fast;
			ratio_ff <= nxt_ratio;
			range_ff <= nxt_range;
			captured_ff <= 1'b1;
		end
	end

	assign rangeCode = range_ff[1:0];
	assign fastTripLevel = fast_ff;
	assign tripRatioSetting = ratio_ff[1:0];

	////////////////////////////////////////////////////////////////////////////
	// Threshold figures in microvolts
	logic [16:0] fsUv;
	logic [16:0] fast_uv_ff, nxt_fastUv;
	logic [16:0] slow_uv_ff, nxt_slowUv;
	logic [31:0] fastProd;

	always_comb
	begin
		case (range_ff[1:0])
			`RANGE_CODE_LOW: fsUv = `FS_LOW_UV;
			`RANGE_CODE_HIGH: fsUv = `FS_HIGH_UV;
			default: fsUv = `FS_OPEN_UV;
		endcase
		fastProd = 32'(fsUv) * (32'(fast_ff) * 32'(`TRIP_SPAN_PCT)
			+ 32'(`TRIP_MIN_PCT * `DAC_FULL));
		nxt_fastUv = 17'(fastProd / 32'(100 * `DAC_FULL));
		case (ratio_ff[1:0])
			2'b00: nxt_slowUv = 17'(32'(fast_uv_ff) * 32'd100 / 32'(`RATIO_PCT_0));
			2'b01: nxt_slowUv = 17'(32'(fast_uv_ff) * 32'd100 / 32'(`RATIO_PCT_1));
			2'b10: nxt_slowUv = 17'(32'(fast_uv_ff) * 32'd100 / 32'(`RATIO_PCT_2));
			default: nxt_slowUv = 17'(32'(fast_uv_ff) * 32'd100 / 32'(`RATIO_PCT_3));
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fast_uv_ff <= 17'h00000;
			slow_uv_ff <= 17'h00000;
		end
		else
		begin
			fast_uv_ff <= nxt_fastUv;
			slow_uv_ff <= nxt_slowUv;
		end
	end

	assign fastTripUv = fast_uv_ff;
	assign slowTripUv = slow_uv_ff;

	////////////////////////////////////////////////////////////////////////////
	// Converter pacing, sample store and warning compare
	logic [31:0] pace_ff, nxt_pace;
	logic start_ff, nxt_start;
	logic alert_ff, nxt_alert;

	always_comb
	begin
		nxt_start = (pace_ff == 32'(SAMPLE_CYCLES - 1));
		nxt_pace = nxt_start ? 32'h00000000 : pace_ff + 32'h00000001;
		nxt_alert = alert_ff;
		if (!powerGoodOut)
			nxt_alert = 1'b0;
		else if (adcDone)
			nxt_alert = (adcData > warnBus.word);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pace_ff <= 32'h00000000;
			start_ff <= 1'b0;
			alert_ff <= 1'b0;
		end
		else
		begin
			pace_ff <= nxt_pace;
			start_ff <= nxt_start;
			alert_ff <= nxt_alert;
		end
	end

	assign adcStart = start_ff;
	assign alertOut = alert_ff;

	split_word_reg #(.WRITABLE(1'b0), .RESET_WORD(`RST_SAMPLE_WORD)) sampleReg (
		.clk(clk),
		.sys_rst(sys_rst),
		.bus(sampleBus),
		.load(adcDone),
		.loadWord(adcData)
	);

	split_word_reg #(.WRITABLE(1'b1), .RESET_WORD(`RST_WARN_WORD)) warnReg (
		.clk(clk),
		.sys_rst(sys_rst),
		.bus(warnBus),
		.load(1'b0),
		.loadWord(10'h000)
	);
endmodule : current_range_and_warning_monitor

`default_nettype wire

// ===== tb/monitor_properties.sv
/*
 Port checker of the current monitor, bound to its top module.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module monitor_properties #(
	parameter int SAMPLE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic rangeSelPinLevel,
	input wire logic rangeSelPinOpen,
	input wire logic powerGoodOut,
	input wire logic protectionModePin,
	input wire logic adcStart,
	input wire logic adcDone,
	input wire monitor_pkg::splitWord_type adcData,
	input wire monitor_pkg::rangeCode_type rangeCode,
	input wire logic [7:0] fastTripLevel,
	input wire logic [1:0] tripRatioSetting,
	input wire logic [16:0] fastTripUv,
	input wire logic [16:0] slowTripUv,
	input wire logic alertOut
);
	import monitor_pkg::*;
	logic [15:0] gapCnt_ff;
	logic [15:0] nxt_gapCnt;
	logic seen_ff;
	logic nxt_seen;
	wire rangeCode_type pinCode = rangeSelPinOpen ? 2'b00 : (rangeSelPinLevel ? 2'b01 : 2'b10);
	////////////////////////////////////////////////////////////
	// Cycles since the previous start pulse
	always_comb
	begin
		nxt_gapCnt = sys_rst ? 16'h0000 : (adcStart ? 16'h0001 : gapCnt_ff + 16'h0001);
		nxt_seen = !sys_rst && (seen_ff || adcStart);
	end
	always_ff @(posedge clk)
	begin
		gapCnt_ff <= nxt_gapCnt;
		seen_ff <= nxt_seen;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	start_gap_a: assert property (adcStart && seen_ff |-> gapCnt_ff == SAMPLE_CYCLES)
		else $error("start spacing off");
	gap_bound_a: assert property (gapCnt_ff <= SAMPLE_CYCLES + 1)
		else $error("start pulse missing");
	alert_pg_a: assert property (!powerGoodOut |=> !alertOut)
		else $error("alert without power-good");
	alert_hold_a: assert property (!adcDone && powerGoodOut |=> $stable(alertOut))
		else $error("alert moved without sample");
	alert_zero_a: assert property (adcDone && adcData == 10'h000 |=> !alertOut)
		else $error("alert on zero sample");
	range_cap_a: assert property ($fell(sys_rst) |=> rangeCode == $past(pinCode))
		else $error("range pin not captured");
	reset_vals_a: assert property ($fell(sys_rst) |->
		fastTripLevel == 8'hbf && tripRatioSetting == 2'b11)
		else $error("bad reset settings");
	ack_edge_a: assert property ($rose(sdaOe) |-> $past(scl, 2) && !$past(scl))
		else $error("data driven off clock fall");
	cover property (powerGoodOut && adcDone ##1 alertOut);
	cover property (protectionModePin && adcDone ##1 alertOut);
	cover property ($rose(sdaOe));
endmodule : monitor_properties
bind current_range_and_warning_monitor monitor_properties
	#(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (
	.clk(clk),
	.sys_rst(sys_rst),
	.scl(scl),
	.sdaIn(sdaIn),
	.sdaOut(sdaOut),
	.sdaOe(sdaOe),
	.rangeSelPinLevel(rangeSelPinLevel),
	.rangeSelPinOpen(rangeSelPinOpen),
	.powerGoodOut(powerGoodOut),
	.protectionModePin(protectionModePin),
	.adcStart(adcStart),
	.adcDone(adcDone),
	.adcData(adcData),
	.rangeCode(rangeCode),
	.fastTripLevel(fastTripLevel),
	.tripRatioSetting(tripRatioSetting),
	.fastTripUv(fastTripUv),
	.slowTripUv(slowTripUv),
	.alertOut(alertOut)
);
`default_nettype wire

// ===== tb/i2c_host_model.sv
/*
 Serial bus host: register write and read transfers.
 Assumes a pull-up on the data wire; phases of two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
	parameter logic [6:0] TARGET = 7'h3a
) (
	input wire logic clk,
	input wire logic sdaIn,
	output logic scl,
	output logic pullLow
);
	int nacks = 0;
	initial
	begin
		scl = 1'b1;
		pullLow = 1'b0;
	end
	// Two clocks per phase, twice the shortest the target takes
	task automatic sc(input logic c);
		@(posedge clk) scl <= c;
		@(posedge clk);
	endtask : sc
	task automatic dt(input logic d);
		@(posedge clk) pullLow <= !d;
		@(posedge clk);
	endtask : dt
	task automatic bitIo(input logic d, output logic q);
		sc(1'b0);
		dt(d);
		sc(1'b1);
		q = sdaIn;
	endtask : bitIo
	task automatic byteIo(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bitIo(d[i], q[i]);
	endtask : byteIo
	task automatic sendByte(input logic [7:0] d);
		logic [7:0] q;
		logic nak;
		byteIo(d, q);
		bitIo(1'b1, nak);
		nacks += int'(nak);
	endtask : sendByte
	task automatic edgeFrame(input logic stop);
		sc(1'b0);
		dt(!stop);
		sc(1'b1);
		dt(stop);
	endtask : edgeFrame
	task automatic writeReg(input logic [7:0] ofs, input logic [7:0] d);
		edgeFrame(1'b0);
		sendByte({TARGET, 1'b0});
		sendByte(ofs);
		sendByte(d);
		edgeFrame(1'b1);
	endtask : writeReg
	task automatic readReg(input logic [7:0] ofs, output logic [7:0] d);
		logic nak;
		edgeFrame(1'b0);
		sendByte({TARGET, 1'b0});
		sendByte(ofs);
		edgeFrame(1'b0);
		sendByte({TARGET, 1'b1});
		byteIo(8'hff, d);
		bitIo(1'b1, nak);
		edgeFrame(1'b1);
	endtask : readReg
endmodule : i2c_host_model
`default_nettype wire

// ===== tb/current_range_and_warning_monitor_tb_top.sv
/*
 Bench of the current monitor: serial host, converter samples, checks.
 Assumes the design, checker and host model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module current_range_and_warning_monitor_tb_top;
	import monitor_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rangeSelPinLevel = 1'b0;
	logic rangeSelPinOpen = 1'b0;
	logic powerGoodOut = 1'b0;
	logic protectionModePin = 1'b0;
	logic adcDone = 1'b0;
	splitWord_type adcData = 10'h000;
	logic scl, pullLow, sdaOut, sdaOe, adcStart, alertOut;
	rangeCode_type rangeCode;
	logic [7:0] fastTripLevel;
	logic [1:0] tripRatioSetting;
	logic [16:0] fastTripUv, slowTripUv;
	wire logic sdaIn;
	int num_errors = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	// Pull-up: low while either side pulls
	assign sdaIn = (pullLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
	current_range_and_warning_monitor #(.SAMPLE_CYCLES(20)) u_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.scl(scl),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.rangeSelPinLevel(rangeSelPinLevel),
		.rangeSelPinOpen(rangeSelPinOpen),
		.powerGoodOut(powerGoodOut),
		.protectionModePin(protectionModePin),
		.adcStart(adcStart),
		.adcDone(adcDone),
		.adcData(adcData),
		.rangeCode(rangeCode),
		.fastTripLevel(fastTripLevel),
		.tripRatioSetting(tripRatioSetting),
		.fastTripUv(fastTripUv),
		.slowTripUv(slowTripUv),
		.alertOut(alertOut)
	);
	i2c_host_model u_host (.clk(clk), .sdaIn(sdaIn), .scl(scl), .pullLow(pullLow));
	////////////////////////////////////////////////////////////
	function automatic logic [16:0] fastExp(input int code, input logic [7:0] dac);
		longint fs;
		fs = (code == 2) ? 25000 : ((code == 1) ? 50000 : 100000);
		return 17'(fs * (dac * 60 + 10200) / 25500);
	endfunction : fastExp
	task automatic summarize();
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic chkVal(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chkVal
	task automatic rdChk(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		u_host.readReg(ofs, d);
		n_compared++;
		if (d !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: reg %h read %h, expected %h", $time, ofs, d, exp);
		end
	endtask : rdChk
	task automatic doReset();
		@(posedge clk) sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
	endtask : doReset
	// Released data lines show the inverse
	task automatic sample(input splitWord_type d);
		@(posedge clk) adcDone <= 1'b1;
		adcData <= d;
		@(posedge clk) adcDone <= 1'b0;
		adcData <= ~d;
		repeat (2) @(posedge clk);
	endtask : sample
	////////////////////////////////////////////////////////////
	initial
	begin
		splitWord_type thr, s;
		logic [7:0] dac;
		void'($urandom(56343));
		for (int p = 0; p < 3; p++)
		begin
			rangeSelPinLevel <= (p == 1);
			rangeSelPinOpen <= (p == 2);
			doReset();
			rdChk(8'h33, (p == 0) ? 8'h02 : ((p == 1) ? 8'h01 : 8'h00));
		end
		rdChk(8'h2e, 8'hbf);
		rdChk(8'h30, 8'h0f);
		rdChk(8'h22, 8'hff);
		rdChk(8'h23, 8'h03);
		for (int c = 0; c < 4; c++)
		begin
			dac = (c == 0) ? 8'h00 : ((c == 3) ? 8'hff : 8'($urandom));
			u_host.writeReg(8'h33, 8'(c));
			u_host.writeReg(8'h30, 8'(3 - c));
			u_host.writeReg(8'h2e, dac);
			repeat (4) @(posedge clk);
			chkVal(17'(rangeCode), 17'(c));
			chkVal(17'(fastTripLevel), 17'(dac));
			chkVal(17'(tripRatioSetting), 17'(3 - c));
			chkVal(fastTripUv, fastExp(c, dac));
			chkVal(slowTripUv, 17'(fastExp(c, dac) * 100 / (125 + 25 * (3 - c))));
		end
		powerGoodOut <= 1'b1;
		repeat (4)
		begin
			s = 10'($urandom);
			sample(s);
			rdChk(8'h00, s[9:2]);
			sample(~s);
			rdChk(8'h01, {6'h00, s[1:0]});
		end
		u_host.writeReg(8'h00, 8'h5a);
		rdChk(8'h00, ~s[9:2]);
		repeat (6)
		begin
			thr = 10'($urandom_range(1022, 1));
			u_host.writeReg(8'h22, thr[9:2]);
			u_host.writeReg(8'h23, {6'h00, thr[1:0]});
			protectionModePin <= 1'($urandom);
			sample(thr + 10'h001);
			chkVal(17'(alertOut), 17'h00001);
			sample(thr);
			chkVal(17'(alertOut), 17'h00000);
		end
		// Raise the alert first so that losing power-good has something to clear
		sample(10'h3ff);
		chkVal(17'(alertOut), 17'h00001);
		powerGoodOut <= 1'b0;
		sample(10'h3ff);
		chkVal(17'(alertOut), 17'h00000);
		powerGoodOut <= 1'b1;
		sample(10'h3ff);
		chkVal(17'(alertOut), 17'h00001);
		// Zero corner: never above any threshold
		sample(10'h000);
		chkVal(17'(alertOut), 17'h00000);
		chkVal(17'(u_host.nacks), 17'h00000);
		summarize();
	end
	// About seven times the expected run
	initial
	begin
		repeat (60000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule : current_range_and_warning_monitor_tb_top
`default_nettype wire
